// *** design/pmc_host.v ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pmc_consts.vh"
module pmc_host (
  input wire i_clock,
  input wire i_nrst,
  // AXI4-Lite slave.
  input wire [3:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [3:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Three-wire serial port to the device.
  output reg o_ser_clk,
  output reg o_ser_data,
  output reg o_ser_load
);
  //--------------------------------------------------------------
  // Serial engine state
  //--------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_LOW = 4'b0010;
  localparam [3:0] ST_HIGH = 4'b0100;
  localparam [3:0] ST_LOAD = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [23:0] data_r;
  reg [23:0] shift_r;
  reg [2:0] sel_r;
  reg [4:0] bit_r;
  reg [7:0] div_r;
  reg [7:0] tick_r;
  reg done_r;
  reg bad_r;
  reg [7:0] words_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg start_r;
  wire [23:0] shadow_q;
  wire [23:0] word_masked;
  wire tick_end;
  wire wr_fire;
  wire busy;

  assign busy = (state_r != ST_IDLE) || start_r;
  assign tick_end = (tick_r == 8'h00);
  assign wr_fire = aw_hold_r && w_hold_r && !o_bvalid;

  // Zero reserved bits so the word obeys the field layout for its select.
  function [23:0] pmc_mask;
    input [2:0] sel;
    input [23:0] w;
    reg [23:0] m;
    begin
      m = 24'h000000;
      case (sel)
        `PMC_SEL_INTEGER: m = (24'h000001 << (`PMC_INT_HI + 1)) - 24'h000001;
        `PMC_SEL_MODULUS: m = (24'h000001 << (`PMC_FRAC_HI + 1)) - 24'h000001;
        `PMC_SEL_FRACTION: m = (24'h000001 << (`PMC_FRAC_HI + 1)) - 24'h000001;
        `PMC_SEL_DITHER: m = (24'h000001 << (`PMC_DITH_HI + 1)) - 24'h000001;
        `PMC_SEL_REFPATH: m = 24'hFFFFFF;
        // LO path layout keeps the linearizer field as written
        `PMC_SEL_LOPATH: m = (24'h000001 << (`PMC_LO_HI + 1)) - 24'h000001;
        `PMC_SEL_OSC: m = (24'h000001 << (`PMC_OSC_HI + 1)) - 24'h000001;
        `PMC_SEL_EXTOSC: m = 24'h000001 << `PMC_EXT_ON_BIT;
        default: m = 24'h000000;
      endcase
      // select code in the low bits
      pmc_mask = (w & m & ~24'h000007) | {21'h000000, sel};
    end
  endfunction

  // Flag settings the host is told to avoid: advisories.
  function pmc_suspect;
    input [2:0] sel;
    input [23:0] w;
    begin
      pmc_suspect = 1'b0;
      // regulators must stay on when internal oscillator is off
      if (sel == `PMC_SEL_OSC && !w[`PMC_OSC_INT_ON_BIT]) begin
        pmc_suspect = !w[`PMC_OSC_REG_ON_BIT] || !w[`PMC_OSC_R33_ON_BIT];
      end
    end
  endfunction

  // Masked word for the current order; its top bit goes out first.
  assign word_masked = pmc_mask(sel_r, data_r);

  //--------------------------------------------------------------
  // Shadow copy of what was last sent
  //--------------------------------------------------------------
  // full replacement of the written register
  pmc_shadow_mem u_shadow (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_we(state_r == ST_LOAD && tick_end),
    .i_waddr(sel_r),
    .i_wdata(shift_r),
    .i_raddr(sel_r),
    .o_rdata(shadow_q)
  );

  //--------------------------------------------------------------
  // AXI4-Lite write channel
  //--------------------------------------------------------------
  // Capture address and data separately; answer once both are held.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `PMC_RESP_OKAY;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      data_r <= 24'h000000;
      sel_r <= 3'h0;
      div_r <= `PMC_DIV_DEF;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      o_awready <= !aw_hold_r && !o_awready && !o_bvalid;
      o_wready <= !w_hold_r && !o_wready && !o_bvalid;
      if (i_awvalid && o_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= `PMC_RESP_OKAY;
        case (awaddr_r)
          `PMC_OFS_DATA: begin
            if (wstrb_r[0]) data_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) data_r[15:8] <= wdata_r[15:8];
            if (wstrb_r[2]) data_r[23:16] <= wdata_r[23:16];
          end
          `PMC_OFS_CTRL: begin
            // Orders arriving while a word is on the wire are refused.
            if (wstrb_r[0] && wdata_r[`PMC_CTRL_GO_BIT]) begin
              if (busy) begin
                o_bresp <= `PMC_RESP_SLVERR;
              end else begin
                sel_r <= wdata_r[`PMC_CTRL_SEL_HI:`PMC_CTRL_SEL_LO];
                start_r <= 1'b1;
              end
            end
          end
          `PMC_OFS_STAT: begin
          end
          `PMC_OFS_DIV: begin
            if (wstrb_r[0] && wdata_r[7:0] != 8'h00) div_r <= wdata_r[7:0];
          end
          default: o_bresp <= `PMC_RESP_SLVERR;
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // AXI4-Lite read channel
  //--------------------------------------------------------------
  // One-cycle answer after the address is taken.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `PMC_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !o_arready;
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= `PMC_RESP_OKAY;
        case (i_araddr)
          `PMC_OFS_DATA: o_rdata <= {8'h00, data_r};
          `PMC_OFS_CTRL: o_rdata <= {28'h0000000, sel_r, 1'b0};
          `PMC_OFS_STAT: o_rdata <= {21'h000000, words_r, bad_r,
                                     done_r, busy};
          `PMC_OFS_DIV: o_rdata <= {24'h000000, div_r};
          default: begin
            o_rdata <= 32'h00000000;
            o_rresp <= `PMC_RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // Serial engine
  //--------------------------------------------------------------
  // Next-state logic for the shift sequence.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_r) state_nxt = ST_LOW;
      ST_LOW: if (tick_end) state_nxt = ST_HIGH;
      ST_HIGH: begin
        if (tick_end) begin
          state_nxt = (bit_r == `PMC_CNT_ZERO) ? ST_LOAD : ST_LOW;
        end
      end
      ST_LOAD: if (tick_end) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // the three wires are the only path to the device.
  // MSB first, data stable across each rising serial edge.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      shift_r <= 24'h000000;
      bit_r <= `PMC_CNT_ZERO;
      tick_r <= 8'h00;
      o_ser_clk <= 1'b0;
      o_ser_data <= 1'b0;
      o_ser_load <= 1'b0;
      done_r <= 1'b0;
      bad_r <= 1'b0;
      words_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      tick_r <= tick_end ? div_r - 8'h01 : tick_r - 8'h01;
      if (start_r) begin
        // Starting a word clears the done flag and reloads the bad flag from the new word.
        done_r <= 1'b0;
        bad_r <= pmc_suspect(sel_r, data_r);
      end
      case (state_r)
        ST_IDLE: begin
          o_ser_clk <= 1'b0;
          o_ser_load <= 1'b0;
          if (start_r) begin
            shift_r <= word_masked;
            o_ser_data <= word_masked[`PMC_WORD_W - 1];
            bit_r <= `PMC_CNT_LAST;
            tick_r <= div_r - 8'h01;
          end
        end
        ST_LOW: begin
          if (tick_end) o_ser_clk <= 1'b1;
        end
        ST_HIGH: begin
          if (tick_end) begin
            o_ser_clk <= 1'b0;
            if (bit_r == `PMC_CNT_ZERO) begin
              // load strobe after the last bit
              o_ser_load <= 1'b1;
            end else begin
              bit_r <= bit_r - 5'h01;
              o_ser_data <= shift_r[bit_r - 5'h01];
            end
          end
        end
        ST_LOAD: begin
          if (tick_end) begin
            o_ser_load <= 1'b0;
            o_ser_data <= 1'b0;
            done_r <= 1'b1;
            words_r <= words_r + 8'h01;
          end
        end
        default: o_ser_load <= 1'b0;
      endcase
    end
  end
endmodule // pmc_host

// *** common/pmc_consts.vh ***
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// Device word layout.
`define PMC_WORD_W 24
`define PMC_SEL_W 3
`define PMC_CNT_W 5
`define PMC_CNT_ZERO 5'h00
`define PMC_CNT_LAST 5'h17
// Register select codes.
`define PMC_SEL_INTEGER 3'h0
`define PMC_SEL_MODULUS 3'h1
`define PMC_SEL_FRACTION 3'h2
`define PMC_SEL_DITHER 3'h3
`define PMC_SEL_REFPATH 3'h4
`define PMC_SEL_LOPATH 3'h5
`define PMC_SEL_OSC 3'h6
`define PMC_SEL_EXTOSC 3'h7
// Field positions inside the device word.
`define PMC_INT_MODE_BIT 10
`define PMC_INT_HI 10
`define PMC_FRAC_HI 13
`define PMC_DITH_HI 22
`define PMC_EXT_ON_BIT 22
`define PMC_OSC_HI 20
`define PMC_LO_HI 11
`define PMC_LO_CAP_HI 11
`define PMC_LO_CAP_LO 8
`define PMC_OSC_INT_ON_BIT 17
`define PMC_OSC_REG_ON_BIT 18
`define PMC_OSC_R33_ON_BIT 19
`define PMC_FIELD_LO 3
// Bus register byte offsets.
`define PMC_ADDR_W 4
`define PMC_OFS_DATA 4'h0
`define PMC_OFS_CTRL 4'h4
`define PMC_OFS_STAT 4'h8
`define PMC_OFS_DIV 4'hC
// Control and status bits.
`define PMC_CTRL_GO_BIT 0
`define PMC_CTRL_SEL_HI 3
`define PMC_CTRL_SEL_LO 1
`define PMC_STAT_BUSY_BIT 0
`define PMC_STAT_DONE_BIT 1
`define PMC_STAT_BAD_BIT 2
`define PMC_STAT_CNT_HI 10
`define PMC_STAT_CNT_LO 3
// Serial clock half period in system clocks (40 ns at 100 MHz).
`define PMC_HALF_NS 40
`define PMC_CLK_NS 10
`define PMC_DIV_W 8
`define PMC_DIV_DEF 8'h04
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

// *** design/pmc_shadow_mem.v ***
`timescale 1ns/1ns
// Eight-word shadow of the write-only device registers; read data registered.
module pmc_shadow_mem (
  input wire i_clock,
  input wire i_nrst,
  input wire i_we,
  input wire [2:0] i_waddr,
  input wire [23:0] i_wdata,
  input wire [2:0] i_raddr,
  output reg [23:0] o_rdata
);
  reg [23:0] mem_r [0:7];
  integer k;

  // Writes and registered read; contents cleared at reset.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < 8; k = k + 1) begin
        mem_r[k] <= 24'h000000;
      end
      o_rdata <= 24'h000000;
    end else begin
      if (i_we) begin
        mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule // pmc_shadow_mem

// *** bench/pmc_host_asserts.sv ***
`timescale 1ns/1ns
// ---------------------------------------------
// Serial framing and bus handshake checks.
// ---------------------------------------------
module pmc_host_asserts (
  input wire i_clock,
  input wire i_nrst,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire i_rready,
  input wire [31:0] o_rdata,
  input wire o_bvalid,
  input wire i_bready,
  input wire [1:0] o_bresp,
  input wire o_ser_clk,
  input wire o_ser_data,
  input wire o_ser_load
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  reg [4:0] edges_r;
  // Counts serial rising edges per frame; timings assume the default
  // divider of four system clocks per half period.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst)
      edges_r <= 5'h00;
    else if (o_ser_load)
      edges_r <= 5'h00;
    else if ($rose(o_ser_clk))
      edges_r <= edges_r + 5'h01;
  end
  sequence s_high4;
    o_ser_clk [*4] ##1 !o_ser_clk;
  endsequence
  sequence s_load4;
    o_ser_load [*4] ##1 !o_ser_load;
  endsequence
  a_clk_high_time: assert property (
    $rose(o_ser_clk) |-> s_high4) else $error("clock high time");
  a_load_width: assert property (
    $rose(o_ser_load) |-> s_load4) else $error("load width");
  a_load_after_24: assert property (
    $rose(o_ser_load) |-> edges_r == 5'h18) else $error("bit count");
  a_clk_low_load: assert property (
    o_ser_load |-> !o_ser_clk) else $error("clock during load");
  a_data_hold_high: assert property (
    o_ser_clk && $past(o_ser_clk) |-> $stable(o_ser_data))
    else $error("data moved");
  a_read_next: assert property (
    i_arvalid && o_arready |=> o_rvalid) else $error("read late");
  a_rvalid_hold: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read dropped");
  a_bvalid_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write resp dropped");
endmodule // pmc_host_asserts

bind pmc_host pmc_host_asserts u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_rdata(o_rdata), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .o_bresp(o_bresp), .o_ser_clk(o_ser_clk),
  .o_ser_data(o_ser_data), .o_ser_load(o_ser_load));

// *** bench/pmc_dev_model.sv ***
`timescale 1ns/1ns
// ---------------------------------------------
// Write-only register bank of the device.
// ---------------------------------------------
module pmc_dev_model (
  input wire i_ser_clk,
  input wire i_ser_data,
  input wire i_ser_load
);
  reg [23:0] shift_r;
  reg [23:0] regs_r [0:7];
  integer bits_r = 0;
  integer got_bits = 0;
  integer loads_r = 0;
  always @(posedge i_ser_clk or posedge i_ser_load) begin
    if (i_ser_load) begin
      regs_r[shift_r[2:0]] <= shift_r;
      got_bits <= bits_r;
      bits_r <= 0;
      loads_r <= loads_r + 1;
    end else begin
      shift_r <= {shift_r[22:0], i_ser_data};
      bits_r <= bits_r + 1;
    end
  end
  wire lo_div_three = regs_r[5][5];
  wire [2:0] monitor_output_select = regs_r[4][23:21];
endmodule // pmc_dev_model

// *** bench/test_pmc_host.sv ***
`timescale 1ns/1ns
`include "pmc_consts.vh"
// ---------------------------------------------
// Bench for the serial configuration host.
// ---------------------------------------------
module test_pmc_host;
  reg i_clock = 0;
  reg i_nrst = 0;
  reg [3:0] awaddr = 0;
  reg [3:0] araddr = 0;
  reg [31:0] wdata = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, sclk, sdata, sload;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer fails = 0, total_checks = 0, cyc = 0, p, s, l0;
  reg [31:0] rd_v;
  reg [1:0] rs;
  reg [23:0] d;
  // Free running system clock.
  always #5 i_clock = ~i_clock;
  pmc_host dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_ser_clk(sclk), .o_ser_data(sdata),
    .o_ser_load(sload));
  pmc_dev_model dev (.i_ser_clk(sclk), .i_ser_data(sdata),
    .i_ser_load(sload));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // A hang counts as a failure and ends the run.
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Slow mode holds the response ready back to test the slave's hold.
  task wr(input [3:0] a, input [31:0] v, input slow);
    integer n;
    begin
      @(posedge i_clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= !slow;
      n = 0;
      forever begin
        @(posedge i_clock);
        n = n + 1;
        if (awvalid && awready) awvalid <= 0;
        if (wvalid && wready) wvalid <= 0;
        if (bready && bvalid) break;
        if (n == 3) bready <= 1;
      end
      rs = bresp;
      bready <= 0;
    end
  endtask
  task rd(input [3:0] a, input slow);
    integer n;
    begin
      @(posedge i_clock);
      araddr <= a;
      arvalid <= 1;
      rready <= !slow;
      n = 0;
      forever begin
        @(posedge i_clock);
        n = n + 1;
        if (arvalid && arready) arvalid <= 0;
        if (rready && rvalid) break;
        if (n == 3) rready <= 1;
      end
      rd_v = rdata;
      rs = rresp;
      rready <= 0;
    end
  endtask
  task wait_done;
    integer n;
    begin
      n = 0;
      rd(`PMC_OFS_STAT, 0);
      while ((rd_v[0] || !rd_v[1]) && n < 200) begin
        rd(`PMC_OFS_STAT, 0);
        n = n + 1;
      end
      if (n == 200) fails = fails + 1;
    end
  endtask
  task send(input [2:0] sl, input [23:0] v);
    begin
      wr(`PMC_OFS_DATA, {8'h00, v}, 0);
      wr(`PMC_OFS_CTRL, {28'h0, sl, 1'b1}, 0);
      chk(rs, `PMC_RESP_OKAY);
      wait_done;
    end
  endtask
  // Data bits that each register keeps; the rest must go out as zero.
  function [23:0] keep(input [2:0] sl);
    case (sl)
      3'h0: keep = 24'h0007F8;
      3'h1, 3'h2: keep = 24'h003FF8;
      3'h3: keep = 24'h7FFFF8;
      3'h4: keep = 24'hFFFFF8;
      3'h5: keep = 24'h000FF8;
      3'h6: keep = 24'h1FFFF8;
      default: keep = 24'h400000;
    endcase
  endfunction
  task t_reset;
    begin
      rd(`PMC_OFS_STAT, 0);
      chk(rd_v, 32'h0);
      rd(`PMC_OFS_DIV, 0);
      chk(rd_v, {24'h0, `PMC_DIV_DEF});
      // A zero divider is ignored; the default is restored for the frames.
      wr(`PMC_OFS_DIV, 32'h6, 0);
      rd(`PMC_OFS_DIV, 0);
      chk(rd_v, 32'h6);
      wr(`PMC_OFS_DIV, 32'h0, 0);
      rd(`PMC_OFS_DIV, 0);
      chk(rd_v, 32'h6);
      wr(`PMC_OFS_DIV, {24'h0, `PMC_DIV_DEF}, 0);
      $display("reset test done");
    end
  endtask
  // All-ones sets the linearizer field to 15 in the LO word.
  task t_words;
    for (p = 0; p < 2; p = p + 1) begin
      for (s = 0; s < 8; s = s + 1) begin
        d = p ? 24'h5A5A5A : 24'hFFFFFF;
        send(s[2:0], d);
        chk(dev.regs_r[s], (d & keep(s[2:0])) | s);
        chk(dut.shadow_q, (d & keep(s[2:0])) | s);
        chk(dev.got_bits, 24);
      end
      $display("word test %0d done", p);
    end
  endtask
  task t_refuse;
    begin
      l0 = dev.loads_r;
      wr(`PMC_OFS_DATA, 32'h000123, 0);
      wr(`PMC_OFS_CTRL, 32'h3, 0);
      wr(`PMC_OFS_CTRL, 32'h5, 1);
      chk(rs, `PMC_RESP_SLVERR);
      wait_done;
      chk(dev.loads_r, l0 + 1);
      chk(dev.regs_r[1], 24'h000121);
      $display("refuse test done");
    end
  endtask
  task t_unmapped;
    begin
      wr(4'h2, 32'h0, 0);
      chk(rs, `PMC_RESP_SLVERR);
      rd(4'h6, 1);
      chk(rs, `PMC_RESP_SLVERR);
      chk(rd_v, 32'h0);
      $display("unmapped test done");
    end
  endtask
  // External oscillator setup: internal off needs regulators kept on.
  task t_suspect;
    begin
      send(3'h6, 24'h080000);
      chk(rd_v[2], 1'b1);
      send(3'h6, 24'h1C0000);
      chk(rd_v[2], 1'b0);
      $display("oscillator test done");
    end
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge i_clock);
    i_nrst <= 1;
    t_reset;
    t_words;
    t_refuse;
    t_unmapped;
    t_suspect;
    close_out;
  end
endmodule // test_pmc_host
